/* hw/port_access_pkg.sv */
package port_access_pkg;

  // ----------------------------------------------------------------
  // Port slots and implemented bits
  // ----------------------------------------------------------------
  localparam int PORT_COUNT = 6;
  localparam int DATA_W     = 8;
  localparam int ALL_W      = PORT_COUNT * DATA_W;

  // Slot order is ports 0, 1, 3, 7, 12, 14.
  localparam logic [3:0] PORT_ID [PORT_COUNT] =
    '{4'h0, 4'h1, 4'h3, 4'h7, 4'hC, 4'hE};
  localparam logic [7:0] PORT_MASK [PORT_COUNT] =
    '{8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h01, 8'h01};

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] LATCH_BASE = 16'hFF00;
  localparam logic [15:0] MODE_BASE  = 16'hFF20;
  localparam logic [15:0] PULLUP_ADDR [PORT_COUNT] =
    '{16'hFF30, 16'hFF31, 16'hFF33, 16'hFF37, 16'hFF3C, 16'hFF3E};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'hFF;
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [7:0] UNMAP_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Bus commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ  = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_SET1  = 3'h2,
    CMD_CLR1  = 3'h3,
    CMD_AND8  = 3'h4,
    CMD_OR8   = 3'h5,
    CMD_XOR8  = 3'h6,
    CMD_NONE  = 3'h7
  } cmd_t;

endpackage : port_access_pkg

/* hw/port_slice.sv */
`timescale 1ns/1ps
`default_nettype none
module port_slice
  import port_access_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       latch_we,
  input  wire logic       mode_we,
  input  wire logic       pu_we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] pin_in,
  input  wire logic [7:0] alt_out_en,
  output logic      [7:0] latch_q,
  output logic      [7:0] mode_q,
  output logic      [7:0] pu_q,
  output logic      [7:0] pin_sync_q,
  output logic      [7:0] pullup_en_q
);

  logic [7:0] latch_d;
  logic [7:0] mode_d;
  logic [7:0] pu_d;
  logic [7:0] pin_meta_q;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Missing bits are pinned to their reset value so reads stay constant.
  assign latch_d = latch_we ? ((wdata & MASK) | (LATCH_RST & ~MASK))
                            : latch_q;
  assign mode_d  = mode_we ? ((wdata & MASK) | (MODE_RST & ~MASK))
                           : mode_q;
  assign pu_d    = pu_we ? ((wdata & MASK) | (PULLUP_RST & ~MASK))
                         : pu_q;

  // Output latch: written in either direction, cleared by reset.
  always_ff @(posedge clk)
  begin
    if (rst)
      latch_q <= LATCH_RST;
    else
      latch_q <= latch_d;
  end

  // Direction register: 1 is input with the buffer off.
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_q <= MODE_RST;
    else
      mode_q <= mode_d;
  end

  // Pull-up select register.
  always_ff @(posedge clk)
  begin
    if (rst)
      pu_q <= PULLUP_RST;
    else
      pu_q <= pu_d;
  end

  // Two-stage pin synchroniser; only the second stage is read.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end
    else
    begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Built from next values so a direction change never leaves a
  // pull-up fighting a driven pin for a cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
      pullup_en_q <= 8'h00;
    else
      pullup_en_q <= pu_d & mode_d & ~alt_out_en & MASK;
  end

endmodule : port_slice
`default_nettype wire

/* hw/port_pullup_and_latch_access.sv */
`timescale 1ns/1ps
`default_nettype none
module port_pullup_and_latch_access
  import port_access_pkg::*;
(
  input  wire logic             SYS_CLK,
  input  wire logic             RST,
  input  wire logic             BUS_REQ,
  input  wire logic [2:0]       BUS_CMD,
  input  wire logic [15:0]      BUS_ADDR,
  input  wire logic [7:0]       BUS_WDATA,
  input  wire logic [2:0]       BUS_BIT,
  output logic      [7:0]       BUS_RDATA,
  output logic                  BUS_RVALID,
  output logic                  BUS_ERR,
  input  wire logic [ALL_W-1:0] PIN_IN,
  input  wire logic [ALL_W-1:0] ALT_OUT_EN,
  output logic      [ALL_W-1:0] PIN_OUT,
  output logic      [ALL_W-1:0] PIN_OE_N,
  output logic      [ALL_W-1:0] PULLUP_EN
);

  // ----------------------------------------------------------------
  // Per-port state
  // ----------------------------------------------------------------
  logic [7:0] latch_v   [PORT_COUNT];
  logic [7:0] mode_v    [PORT_COUNT];
  logic [7:0] pu_v      [PORT_COUNT];
  logic [7:0] pin_v     [PORT_COUNT];
  logic [7:0] pull_v    [PORT_COUNT];
  logic [PORT_COUNT-1:0] hit_latch;
  logic [PORT_COUNT-1:0] hit_mode;
  logic [PORT_COUNT-1:0] hit_pu;
  logic       mapped;
  logic       do_write;
  logic [7:0] operand;
  logic [7:0] result;
  logic [7:0] bit_mask;
  cmd_t       cmd;

  assign cmd      = cmd_t'(BUS_CMD);
  assign bit_mask = 8'h01 << BUS_BIT;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Each slot compares against its own three addresses.
  always_comb
  begin
    hit_latch = '0;
    hit_mode  = '0;
    hit_pu    = '0;
    for (int i = 0; i < PORT_COUNT; i++)
    begin
      hit_latch[i] = BUS_ADDR == (LATCH_BASE | {12'h000, PORT_ID[i]});
      hit_mode[i]  = BUS_ADDR == (MODE_BASE | {12'h000, PORT_ID[i]});
      hit_pu[i]    = BUS_ADDR == PULLUP_ADDR[i];
    end
  end

  assign mapped = |{hit_latch, hit_mode, hit_pu};

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  // A port read mixes latch bits of output pins with pin levels of
  // input pins, whole byte at once; this is also the operand of every
  // modify so input-mode latch bits pick up the pin level.
  always_comb
  begin
    operand = UNMAP_DATA;
    for (int i = 0; i < PORT_COUNT; i++)
    begin
      if (hit_latch[i])
        operand = ((latch_v[i] & ~mode_v[i]) | (pin_v[i] & mode_v[i]))
                  & PORT_MASK[i];
      else if (hit_mode[i])
        operand = mode_v[i];
      else if (hit_pu[i])
        operand = pu_v[i];
    end
  end

  // ----------------------------------------------------------------
  // Modify
  // ----------------------------------------------------------------
  // Bit commands modify one bit of the fetched byte and write back all
  // eight, so untouched input-mode latch bits may change.
  always_comb
  begin
    result   = operand;
    do_write = 1'b0;
    unique case (cmd)
      CMD_READ:
      begin
        result   = operand;
        do_write = 1'b0;
      end
      CMD_WRITE:
      begin
        result   = BUS_WDATA;
        do_write = 1'b1;
      end
      CMD_SET1:
      begin
        result   = operand | bit_mask;
        do_write = 1'b1;
      end
      CMD_CLR1:
      begin
        result   = operand & ~bit_mask;
        do_write = 1'b1;
      end
      CMD_AND8:
      begin
        result   = operand & BUS_WDATA;
        do_write = 1'b1;
      end
      CMD_OR8:
      begin
        result   = operand | BUS_WDATA;
        do_write = 1'b1;
      end
      CMD_XOR8:
      begin
        result   = operand ^ BUS_WDATA;
        do_write = 1'b1;
      end
      CMD_NONE:
      begin
        result   = operand;
        do_write = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Port slices
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PORT_COUNT; g++)
    begin : g_port
      port_slice #(
        .MASK (PORT_MASK[g])
      ) u_slice (
        .clk         (SYS_CLK),
        .rst         (RST),
        .latch_we    (BUS_REQ && do_write && hit_latch[g]),
        .mode_we     (BUS_REQ && do_write && hit_mode[g]),
        .pu_we       (BUS_REQ && do_write && hit_pu[g]),
        .wdata       (result),
        .pin_in      (PIN_IN[g*DATA_W +: DATA_W]),
        .alt_out_en  (ALT_OUT_EN[g*DATA_W +: DATA_W]),
        .latch_q     (latch_v[g]),
        .mode_q      (mode_v[g]),
        .pu_q        (pu_v[g]),
        .pin_sync_q  (pin_v[g]),
        .pullup_en_q (pull_v[g])
      );
      // Pin pads see the flops directly; the latch is driven only
      // where the direction bit is 0.
      assign PIN_OUT[g*DATA_W +: DATA_W]   = latch_v[g];
      assign PIN_OE_N[g*DATA_W +: DATA_W]  = mode_v[g];
      assign PULLUP_EN[g*DATA_W +: DATA_W] = pull_v[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  // Every request is answered one cycle later; commands that modify
  // return the operand they worked on.
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      BUS_RDATA  <= 8'h00;
      BUS_RVALID <= 1'b0;
    end
    else
    begin
      BUS_RVALID <= BUS_REQ;
      if (BUS_REQ)
        BUS_RDATA <= operand;
    end
  end

  // Unmapped addresses and the spare command code are flagged, not
  // acted on; writes to them are simply lost.
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      BUS_ERR <= 1'b0;
    else
      BUS_ERR <= BUS_REQ && (!mapped || cmd == CMD_NONE);
  end

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  logic             lat_req;
  logic             pu_req;
  logic [ALL_W-1:0] port_mask_all;

  assign lat_req = BUS_REQ && do_write && |hit_latch;
  assign pu_req  = BUS_REQ && do_write && |hit_pu;

  always_comb
  begin
    port_mask_all = '0;
    for (int i = 0; i < PORT_COUNT; i++)
      port_mask_all[i*DATA_W +: DATA_W] = PORT_MASK[i];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_write_port1;
    BUS_REQ && cmd == CMD_WRITE && hit_latch[1];
  endsequence

  sequence s_read_req;
    BUS_REQ && !do_write && mapped;
  endsequence

  sequence s_mode_write_port1;
    BUS_REQ && cmd == CMD_WRITE && hit_mode[1];
  endsequence

  AST_PULLUP_ONLY_INPUT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (PULLUP_EN & ~(PIN_OE_N & port_mask_all)) == '0)
    else $error("Pull-up enabled on a pin that is not an input.");

  AST_PULLUP_NOT_ALT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !$past(RST) |-> (PULLUP_EN & $past(ALT_OUT_EN)) == '0)
    else $error("Pull-up enabled on an alternate-function output.");

  AST_RESET_CLEARS: assert property (
    @(posedge SYS_CLK)
    $past(RST) |-> PULLUP_EN == '0 && PIN_OUT == '0 && pu_v[1] == 8'h00)
    else $error("Reset left a pull-up or latch set.");

  AST_PULLUP_FOLLOWS_SELECT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (pu_req && hit_pu[3] && cmd == CMD_WRITE && BUS_WDATA == 8'hFF
     && mode_v[3] == 8'hFF && ALT_OUT_EN[31:24] == 8'h00
     && !(BUS_REQ && do_write && hit_mode[3]))
    |=> PULLUP_EN[31:24] == 8'hFF)
    else $error("Pull-up select 1 did not connect the resistor.");

  AST_PULLUP_BIT_WRITE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (pu_req && cmd == CMD_SET1 && hit_pu[1])
    |=> pu_v[1] == ($past(pu_v[1]) | $past(bit_mask)))
    else $error("Single-bit pull-up write lost.");

  AST_BIT_RMW_BYTE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (lat_req && cmd == CMD_CLR1 && hit_latch[1])
    |=> latch_v[1] == ($past(operand) & ~$past(bit_mask)))
    else $error("Bit operation was not a full-byte write-back.");

  AST_WRITE_DRIVES_PIN: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    s_write_port1 |=> PIN_OUT[15:8] == $past(BUS_WDATA))
    else $error("Write did not reach the output latch.");

  AST_LATCH_HOLDS: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !(lat_req && hit_latch[1]) |=> $stable(PIN_OUT[15:8]))
    else $error("Output latch changed without a write.");

  AST_INPUT_WRITE_UNDRIVEN: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (s_write_port1 ##0 mode_v[1] == 8'hFF
     ##1 !(BUS_REQ && do_write && hit_mode[1]))
    |=> PIN_OE_N[15:8] == 8'hFF)
    else $error("Input-mode write turned on the output buffer.");

  AST_READ_VALUE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (s_read_req ##0 hit_latch[1])
    |=> BUS_RVALID && BUS_RDATA ==
        (($past(latch_v[1]) & ~$past(mode_v[1]))
         | ($past(pin_v[1]) & $past(mode_v[1])))
        && $stable(latch_v[1]))
    else $error("Port read returned the wrong source or moved the latch.");

  AST_OP_OUTPUT_MODE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (lat_req && cmd == CMD_XOR8 && hit_latch[3] && mode_v[3] == 8'h00)
    |=> PIN_OUT[31:24] == ($past(latch_v[3]) ^ $past(BUS_WDATA)))
    else $error("Output-mode operation did not use the latch.");

  AST_OP_INPUT_MODE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (lat_req && cmd == CMD_OR8 && hit_latch[3] && mode_v[3] == 8'hFF)
    |=> latch_v[3] == ($past(pin_v[3]) | $past(BUS_WDATA))
        && PIN_OE_N[31:24] == 8'hFF)
    else $error("Input-mode operation did not use the pin level.");

  // ----------------------------------------------------------------
  // Reset, answer and refusal checks
  // ----------------------------------------------------------------
  // Reset and unused-bit checks watch whole buses so a slot wired to the wrong lane shows up at once;
  // the refusal check covers both pin buses but only the pull-up select of slot 0.
  AST_LATCH_RESET: assert property (
    @(posedge SYS_CLK)
    $past(RST) |-> PIN_OUT == '0)
    else $error("Reset left an output latch bit set.");

  AST_DIR_RESET: assert property (
    @(posedge SYS_CLK)
    $past(RST) |-> PIN_OE_N == '1)
    else $error("Reset left an output buffer on.");

  AST_DIR_WRITE: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    s_mode_write_port1 |=> PIN_OE_N[15:8] == $past(BUS_WDATA))
    else $error("Direction write did not reach the output buffer.");

  AST_UNUSED_BITS: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (PIN_OUT & ~port_mask_all) == '0
    && (PIN_OE_N | port_mask_all) == '1)
    else $error("A missing pin bit left its reset value.");

  AST_ANSWER_NEXT: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    BUS_REQ |=> BUS_RVALID)
    else $error("A request was not answered in the next cycle.");

  AST_NO_STRAY_ANSWER: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !BUS_REQ |=> !BUS_RVALID && !BUS_ERR)
    else $error("Answer or error pulse without a request.");

  AST_REFUSED_HOLDS: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (BUS_REQ && (!mapped || cmd == CMD_NONE))
    |=> $stable(PIN_OUT) && $stable(PIN_OE_N) && $stable(pu_v[0]))
    else $error("A refused request changed a register.");

  AST_UNMAPPED_ERR: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    (BUS_REQ && !mapped)
    |=> BUS_ERR && BUS_RVALID && BUS_RDATA == UNMAP_DATA)
    else $error("Unmapped request not flagged or returned data.");

endmodule : port_pullup_and_latch_access
`default_nettype wire

/* bench/pin_board.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_board
  import port_access_pkg::*;
(
  input  wire logic             clk,
  input  wire logic [ALL_W-1:0] pin_out,
  input  wire logic [ALL_W-1:0] oe_n,
  input  wire logic [ALL_W-1:0] pu_en,
  input  wire logic [ALL_W-1:0] drv,
  input  wire logic [ALL_W-1:0] drv_en,
  output logic      [ALL_W-1:0] pin_in
);
  logic [ALL_W-1:0] flt_q = '0;

  // A floating pin wanders every cycle, so no read may lean on it.
  always @(posedge clk)
  begin
    flt_q <= ~flt_q;
  end

  // The chip's driver wins, then the board, then the pull-up.
  always_comb
  begin
    for (int i = 0; i < ALL_W; i++)
      pin_in[i] = !oe_n[i] ? pin_out[i] : drv_en[i] ? drv[i] :
                  pu_en[i] ? 1'b1 : flt_q[i];
  end
endmodule : pin_board
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import port_access_pkg::*;
;
  typedef struct {
    cmd_t        cmd;
    logic [15:0] adr;
    logic [7:0]  wd;
    logic [2:0]  bt;
    logic [7:0]  ex;
    logic        er;
  } row_t;

  logic             SYS_CLK, RST, BUS_REQ, BUS_RVALID, BUS_ERR;
  logic [2:0]       BUS_CMD, BUS_BIT;
  logic [15:0]      BUS_ADDR;
  logic [7:0]       BUS_WDATA, BUS_RDATA, rd;
  logic [ALL_W-1:0] PIN_IN, ALT_OUT_EN, PIN_OUT, PIN_OE_N, PULLUP_EN;
  logic [ALL_W-1:0] drv, drv_en;
  logic             er;
  int               fails, checks;

  // Ordinary accesses, in order; later rows lean on earlier ones.
  row_t rows [28] = '{
    '{CMD_READ,  16'hFF30, 8'h00, 3'h0, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF3E, 8'h00, 3'h0, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF20, 8'h00, 3'h0, 8'hFF, 1'b0},
    '{CMD_READ,  16'hFF01, 8'h00, 3'h0, 8'h3C, 1'b0},
    '{CMD_WRITE, 16'hFF21, 8'h0F, 3'h0, 8'h00, 1'b0},
    '{CMD_WRITE, 16'hFF01, 8'hA5, 3'h0, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF01, 8'h00, 3'h0, 8'hAC, 1'b0},
    '{CMD_SET1,  16'hFF01, 8'h00, 3'h7, 8'h00, 1'b0},
    '{CMD_XOR8,  16'hFF01, 8'h03, 3'h0, 8'h00, 1'b0},
    '{CMD_CLR1,  16'hFF01, 8'h00, 3'h5, 8'h00, 1'b0},
    '{CMD_WRITE, 16'hFF31, 8'hFF, 3'h0, 8'h00, 1'b0},
    '{CMD_CLR1,  16'hFF31, 8'h00, 3'h7, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF31, 8'h00, 3'h0, 8'h7F, 1'b0},
    '{CMD_SET1,  16'hFF31, 8'h00, 3'h7, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF31, 8'h00, 3'h0, 8'hFF, 1'b0},
    '{CMD_WRITE, 16'hFF3C, 8'hFF, 3'h0, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF3C, 8'h00, 3'h0, 8'h01, 1'b0},
    '{CMD_WRITE, 16'hFF37, 8'hFF, 3'h0, 8'h00, 1'b0},
    '{CMD_OR8,   16'hFF07, 8'h01, 3'h0, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF07, 8'h00, 3'h0, 8'h3C, 1'b0},
    '{CMD_WRITE, 16'hFF27, 8'h00, 3'h0, 8'h00, 1'b0},
    '{CMD_WRITE, 16'hFF07, 8'hF0, 3'h0, 8'h00, 1'b0},
    '{CMD_OR8,   16'hFF07, 8'h0F, 3'h0, 8'h00, 1'b0},
    '{CMD_AND8,  16'hFF07, 8'h3C, 3'h0, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF07, 8'h00, 3'h0, 8'h3C, 1'b0},
    '{CMD_XOR8,  16'hFF07, 8'hFF, 3'h0, 8'h00, 1'b0},
    '{CMD_READ,  16'hFF3F, 8'h00, 3'h0, 8'h00, 1'b1},
    '{CMD_NONE,  16'hFF30, 8'h00, 3'h0, 8'h00, 1'b1}
  };

  port_pullup_and_latch_access i_dut (
    .SYS_CLK    (SYS_CLK),
    .RST        (RST),
    .BUS_REQ    (BUS_REQ),
    .BUS_CMD    (BUS_CMD),
    .BUS_ADDR   (BUS_ADDR),
    .BUS_WDATA  (BUS_WDATA),
    .BUS_BIT    (BUS_BIT),
    .BUS_RDATA  (BUS_RDATA),
    .BUS_RVALID (BUS_RVALID),
    .BUS_ERR    (BUS_ERR),
    .PIN_IN     (PIN_IN),
    .ALT_OUT_EN (ALT_OUT_EN),
    .PIN_OUT    (PIN_OUT),
    .PIN_OE_N   (PIN_OE_N),
    .PULLUP_EN  (PULLUP_EN)
  );

  pin_board i_board (
    .clk    (SYS_CLK),
    .pin_out(PIN_OUT),
    .oe_n   (PIN_OE_N),
    .pu_en  (PULLUP_EN),
    .drv    (drv),
    .drv_en (drv_en),
    .pin_in (PIN_IN)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One request, launched and dropped on falling edges; the answer is
  // taken half a cycle after the edge that accepted it.
  task automatic bus(input row_t r, output logic [7:0] d,
                     output logic e);
    @(negedge SYS_CLK);
    BUS_REQ   = 1'b1;
    BUS_CMD   = r.cmd;
    BUS_ADDR  = r.adr;
    BUS_WDATA = r.wd;
    BUS_BIT   = r.bt;
    @(negedge SYS_CLK);
    BUS_REQ = 1'b0;
    check(BUS_RVALID, 1'b1);
    d = BUS_RDATA;
    e = BUS_ERR;
  endtask : bus

  task automatic results;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // Free-running clock, 8 ns period.
  initial
  begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  // A hang is cut well after the roughly 71 cycles the run needs.
  initial
  begin
    #100us;
    fails++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {RST, BUS_REQ, BUS_CMD, BUS_ADDR, BUS_WDATA, BUS_BIT} = '0;
    RST = 1'b1;
    ALT_OUT_EN = '0;
    drv = {PORT_COUNT{8'h3C}};
    drv_en = '1;
    fails = 0;
    checks = 0;
    repeat (4) @(negedge SYS_CLK);
    RST = 1'b0;
    foreach (rows[i])
    begin
      bus(rows[i], rd, er);
      check(er, rows[i].er);
      if (rows[i].cmd == CMD_READ || rows[i].er)
        check(rd, rows[i].ex);
    end
    $display("table done");
    // Mixed port: input bits took pin level on each modify.
    check(PIN_OUT[15:8], 8'h8C);
    check(PIN_OE_N[15:8], 8'h0F);
    check(PIN_OUT[31:24], 8'hC3);
    // Pull-ups only on input bits, and not on an alternate output.
    check(PULLUP_EN[15:8], 8'h0F);
    check(PULLUP_EN[39:32], 8'h01);
    check(PULLUP_EN[31:24], 8'h00);
    ALT_OUT_EN[8] = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    check(PULLUP_EN[15:8], 8'h0E);
    $display("pull-up test done");
    // Latch survives a turn to input, and a write there stays hidden.
    bus('{CMD_WRITE, 16'hFF21, 8'hFF, 3'h0, 8'h00, 1'b0}, rd, er);
    check(PIN_OUT[15:8], 8'h8C);
    bus('{CMD_WRITE, 16'hFF01, 8'h00, 3'h0, 8'h00, 1'b0}, rd, er);
    check(PIN_OUT[15:8], 8'h00);
    check(PIN_OE_N[15:8], 8'hFF);
    $display("latch test done");
    // Reset in mid-run clears latches and pull-up selects.
    @(negedge SYS_CLK);
    RST = 1'b1;
    repeat (2) @(negedge SYS_CLK);
    RST = 1'b0;
    check(PIN_OUT, '0);
    check(PULLUP_EN, '0);
    check(PIN_OE_N, '1);
    bus('{CMD_READ, 16'hFF37, 8'h00, 3'h0, 8'h00, 1'b0}, rd, er);
    check(rd, 8'h00);
    $display("reset test done");
    results();
  end
endmodule : tb
`default_nettype wire
